// file: common/mmu_timing_regs.vh
// mmu instruction timing constants
`ifndef MMU_TIMING_REGS_VH
`define MMU_TIMING_REGS_VH
// ****************************
// operation codes
// ****************************
`define OP_RD_ROOT       4'h0
`define OP_WR_ROOT_OK    4'h1
`define OP_WR_ROOT_BAD   4'h2
`define OP_RD_WIN        4'h3
`define OP_WR_WIN        4'h4
`define OP_WR_TC_ON      4'h5
`define OP_WR_TC_BAD     4'h6
`define OP_FLUSH_IMM     4'h7
`define OP_FLUSH_FCR     4'h8
`define OP_PRELOAD_IMM   4'h9
`define OP_PRELOAD_FCR   4'hA
`define OP_PROBE6        4'hB
// ****************************
// clock counts, cached / uncached
// ****************************
`define CLK_RD_ROOT_C    8'h04
`define CLK_RD_ROOT_U    8'h05
`define CLK_WR_ROOT_C    8'h0C
`define CLK_WR_ROOT_U    8'h0E
`define CLK_BAD_ROOT_C   8'h1C
`define CLK_BAD_ROOT_U   8'h1E
`define CLK_RD_WIN_C     8'h08
`define CLK_RD_WIN_U     8'h08
`define CLK_WR_WIN_C     8'h0C
`define CLK_WR_WIN_U     8'h0E
`define CLK_TC_ON_C      8'h26
`define CLK_TC_ON_U      8'h28
`define CLK_TC_BAD_C     8'h38
`define CLK_TC_BAD_U     8'h3A
`define CLK_FL_IMM_C     8'h10
`define CLK_FL_IMM_U     8'h12
`define CLK_FL_FCR_C     8'h14
`define CLK_FL_FCR_U     8'h16
`define CLK_PL_IMM_C     8'h08
`define CLK_PL_IMM_U     8'h0A
`define CLK_PL_FCR_C     8'h0C
`define CLK_PL_FCR_U     8'h0E
`define CLK_PROBE_C      8'h58
`define CLK_PROBE_U      8'h58
// ****************************
// bus cycle mix {reads, prefetches, writes}, then the probe clock tail
// ****************************
`define MIX_RD_ROOT_C    12'h002
`define MIX_RD_ROOT_U    12'h012
`define MIX_WR_ROOT_C    12'h200
`define MIX_WR_ROOT_U    12'h220
`define MIX_BAD_ROOT_C   12'h304
`define MIX_BAD_ROOT_U   12'h324
`define MIX_RD_WIN_C     12'h001
`define MIX_RD_WIN_U     12'h011
`define MIX_WR_WIN_C     12'h100
`define MIX_WR_WIN_U     12'h120
`define MIX_TC_ON_C      12'h100
`define MIX_TC_ON_U      12'h120
`define MIX_TC_BAD_C     12'h204
`define MIX_TC_BAD_U     12'h224
`define MIX_NONE_C       12'h000
`define MIX_NONE_U       12'h020
`define MIX_PROBE_C      12'hC00
`define MIX_PROBE_U      12'hC10
`define PROBE_TAIL       8'h01
`endif

// file: design/mmu_cycle_table.v
// lookup of clock count and bus cycle mix per operation
`timescale 1ns/1ps
`include "mmu_timing_regs.vh"
module mmu_cycle_table (
  input wire [3:0] op_i,
  input wire cached_i,
  output reg [7:0] clocks_o,
  output reg [11:0] mix_o,
  output reg known_o
);
  always @* begin
    known_o = 1'b1;
    case (op_i)
      `OP_RD_ROOT: begin
        clocks_o = cached_i ? `CLK_RD_ROOT_C : `CLK_RD_ROOT_U;
        mix_o = cached_i ? `MIX_RD_ROOT_C : `MIX_RD_ROOT_U;
      end
      `OP_WR_ROOT_OK: begin
        clocks_o = cached_i ? `CLK_WR_ROOT_C : `CLK_WR_ROOT_U;
        mix_o = cached_i ? `MIX_WR_ROOT_C : `MIX_WR_ROOT_U;
      end
      `OP_WR_ROOT_BAD: begin
        clocks_o = cached_i ? `CLK_BAD_ROOT_C : `CLK_BAD_ROOT_U;
        mix_o = cached_i ? `MIX_BAD_ROOT_C : `MIX_BAD_ROOT_U;
      end
      `OP_RD_WIN: begin
        clocks_o = cached_i ? `CLK_RD_WIN_C : `CLK_RD_WIN_U;
        mix_o = cached_i ? `MIX_RD_WIN_C : `MIX_RD_WIN_U;
      end
      `OP_WR_WIN: begin
        clocks_o = cached_i ? `CLK_WR_WIN_C : `CLK_WR_WIN_U;
        mix_o = cached_i ? `MIX_WR_WIN_C : `MIX_WR_WIN_U;
      end
      `OP_WR_TC_ON: begin
        clocks_o = cached_i ? `CLK_TC_ON_C : `CLK_TC_ON_U;
        mix_o = cached_i ? `MIX_TC_ON_C : `MIX_TC_ON_U;
      end
      `OP_WR_TC_BAD: begin
        clocks_o = cached_i ? `CLK_TC_BAD_C : `CLK_TC_BAD_U;
        mix_o = cached_i ? `MIX_TC_BAD_C : `MIX_TC_BAD_U;
      end
      `OP_FLUSH_IMM: begin
        clocks_o = cached_i ? `CLK_FL_IMM_C : `CLK_FL_IMM_U;
        mix_o = cached_i ? `MIX_NONE_C : `MIX_NONE_U;
      end
      `OP_FLUSH_FCR: begin
        clocks_o = cached_i ? `CLK_FL_FCR_C : `CLK_FL_FCR_U;
        mix_o = cached_i ? `MIX_NONE_C : `MIX_NONE_U;
      end
      `OP_PRELOAD_IMM: begin
        clocks_o = cached_i ? `CLK_PL_IMM_C : `CLK_PL_IMM_U;
        mix_o = cached_i ? `MIX_NONE_C : `MIX_NONE_U;
      end
      `OP_PRELOAD_FCR: begin
        clocks_o = cached_i ? `CLK_PL_FCR_C : `CLK_PL_FCR_U;
        mix_o = cached_i ? `MIX_NONE_C : `MIX_NONE_U;
      end
      `OP_PROBE6: begin
        clocks_o = cached_i ? `CLK_PROBE_C : `CLK_PROBE_U;
        mix_o = cached_i ? `MIX_PROBE_C : `MIX_PROBE_U;
      end
      default: begin
        clocks_o = 8'h00;
        mix_o = 12'h000;
        known_o = 1'b0;
      end
    endcase
  end
endmodule

// file: design/mmu_instruction_timing_model.v
// timing model of memory-management instructions
`timescale 1ns/1ps
`include "mmu_timing_regs.vh"
module mmu_instruction_timing_model (
  input wire clk_i,
  input wire reset_i,
  input wire ce_i,
  input wire start_i,
  input wire [3:0] op_i,
  input wire icache_hit_i,
  input wire [7:0] ea_clocks_i,
  input wire [7:0] search_clocks_i,
  input wire irq_i,
  input wire bus_req_i,
  output reg busy_o,
  output reg done_o,
  output reg bad_op_o,
  output reg [8:0] total_clocks_o,
  output reg [3:0] reads_o,
  output reg [3:0] prefetches_o,
  output reg [3:0] writes_o,
  output reg irq_take_o,
  output reg bus_grant_o,
  output reg locked_o
);
  // ****************************
  // states
  // ****************************
  localparam [2:0] S_IDLE = 3'b001;
  localparam [2:0] S_RUN = 3'b010;
  localparam [2:0] S_SEARCH = 3'b100;

  reg [2:0] state_r;
  reg [2:0] state_nxt;
  reg [8:0] count_r;
  reg [8:0] count_nxt;
  reg [7:0] search_r;
  reg irq_pend_r;
  wire [7:0] tab_clocks;
  wire [11:0] tab_mix;
  wire tab_known;
  reg [8:0] base_total;
  reg adds_ea;
  reg adds_search;
  reg [7:0] tail;

  mmu_cycle_table u_table (
    .op_i(op_i),
    .cached_i(icache_hit_i),
    .clocks_o(tab_clocks),
    .mix_o(tab_mix),
    .known_o(tab_known)
  );

  // ****************************
  // per-op extras
  // ****************************
  always @* begin
    adds_ea = 1'b0;
    adds_search = 1'b0;
    tail = 8'h00;
    case (op_i)
      `OP_FLUSH_IMM, `OP_FLUSH_FCR: adds_ea = 1'b0;
      `OP_PRELOAD_IMM, `OP_PRELOAD_FCR: begin
        adds_ea = 1'b1;
        adds_search = 1'b1;
      end
      `OP_PROBE6: begin
        adds_ea = 1'b1;
        tail = `PROBE_TAIL;
      end
      default: adds_ea = 1'b1;
    endcase
    base_total = {1'b0, tab_clocks} + (adds_ea ? {1'b0, ea_clocks_i} : 9'h000) + {1'b0, tail};
  end

  // ****************************
  // sequencer
  // ****************************
  always @* begin
    state_nxt = state_r;
    count_nxt = count_r;
    case (state_r)
      S_IDLE: begin
        if (start_i && tab_known) begin
          count_nxt = base_total;
          state_nxt = S_RUN;
        end
      end
      S_RUN: begin
        if (count_r <= 9'h001) begin
          if (search_r != 8'h00) begin
            count_nxt = {1'b0, search_r};
            state_nxt = S_SEARCH;
          end else begin
            state_nxt = S_IDLE;
          end
        end else begin
          count_nxt = count_r - 9'h001;
        end
      end
      S_SEARCH: begin
        if (count_r <= 9'h001) begin
          state_nxt = S_IDLE;
        end else begin
          count_nxt = count_r - 9'h001;
        end
      end
      default: state_nxt = S_IDLE;
    endcase
  end

  always @(posedge clk_i) begin
    if (reset_i) begin
      state_r <= S_IDLE;
      count_r <= 9'h000;
      search_r <= 8'h00;
      irq_pend_r <= 1'b0;
      busy_o <= 1'b0;
      done_o <= 1'b0;
      bad_op_o <= 1'b0;
      total_clocks_o <= 9'h000;
      reads_o <= 4'h0;
      prefetches_o <= 4'h0;
      writes_o <= 4'h0;
      irq_take_o <= 1'b0;
      bus_grant_o <= 1'b0;
      locked_o <= 1'b0;
    end else if (ce_i) begin
      state_r <= state_nxt;
      count_r <= count_nxt;
      done_o <= 1'b0;
      bad_op_o <= 1'b0;
      irq_take_o <= 1'b0;
      if (state_r == S_IDLE && start_i) begin
        bad_op_o <= ~tab_known;
        if (tab_known) begin
          search_r <= adds_search ? search_clocks_i : 8'h00;
          total_clocks_o <= base_total;
          reads_o <= tab_mix[11:8];
          prefetches_o <= tab_mix[7:4];
          writes_o <= tab_mix[3:0];
        end
      end
      if (state_r == S_SEARCH && count_r == {1'b0, search_r}) begin
        total_clocks_o <= total_clocks_o + {1'b0, search_r};
      end
      // asynchronous request is held until an instruction ends
      if (state_nxt == S_IDLE && state_r != S_IDLE) begin
        done_o <= 1'b1;
        irq_take_o <= irq_pend_r | irq_i;
        irq_pend_r <= 1'b0;
      end else if (irq_i) begin
        irq_pend_r <= 1'b1;
      end
      busy_o <= (state_nxt != S_IDLE);
      // whole table search is locked; grant latency bounded by the search length
      locked_o <= (state_nxt == S_SEARCH);
      bus_grant_o <= bus_req_i && (state_nxt != S_SEARCH);
    end
  end
endmodule

// file: dv/mmu_bus_partner.sv
// other bus master contending for the processor bus
`timescale 1ns/1ps
module mmu_bus_partner (
  input wire clk_i,
  input wire reset_i,
  input wire grant_i,
  output reg bus_req_o
);
  // asks at random, also mid search, to load the lock
  always @(posedge clk_i) begin
    if (reset_i || grant_i) begin
      bus_req_o <= 1'b0;
    end else begin
      bus_req_o <= $urandom_range(0, 1);
    end
  end
endmodule

// file: dv/mmu_instruction_timing_model_bench.sv
// self-checking bench for the mmu timing model
`timescale 1ns/1ps
module mmu_instruction_timing_model_bench;
  reg clk_i = 0, reset_i = 1, start_i = 0, hit = 0, irq = 0, ce = 1;
  reg [3:0] op = 4'h0;
  reg [7:0] ea = 8'h00, srch = 8'h00;
  wire req, busy, done, bad, itake, grant, lock;
  wire [8:0] tot;
  wire [3:0] rd, pf, wr;
  int n_fail = 0, n_checks = 0;
  int tc[12] = '{4, 12, 28, 8, 12, 38, 56, 16, 20, 8, 12, 88};
  int tu[12] = '{5, 14, 30, 8, 14, 40, 58, 18, 22, 10, 14, 88};
  int mr[12] = '{0, 2, 3, 0, 1, 1, 2, 0, 0, 0, 0, 12};
  int mp[12] = '{1, 2, 2, 1, 2, 2, 2, 2, 2, 2, 2, 1};
  int mw[12] = '{2, 0, 4, 1, 0, 0, 4, 0, 0, 0, 0, 0};
  mmu_instruction_timing_model i_dut (.clk_i(clk_i), .reset_i(reset_i), .ce_i(ce), .start_i(start_i),
    .op_i(op), .icache_hit_i(hit), .ea_clocks_i(ea), .search_clocks_i(srch), .irq_i(irq), .bus_req_i(req),
    .busy_o(busy), .done_o(done), .bad_op_o(bad), .total_clocks_o(tot), .reads_o(rd), .prefetches_o(pf),
    .writes_o(wr), .irq_take_o(itake), .bus_grant_o(grant), .locked_o(lock));
  mmu_bus_partner i_mem (.clk_i(clk_i), .reset_i(reset_i), .grant_i(grant), .bus_req_o(req));
  initial forever #4 clk_i = ~clk_i;
  task check(input [15:0] seen, input [15:0] exp);
    n_checks++;
    if (seen !== exp) begin
      n_fail++;
      $display("MISMATCH t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask
  task close_out;
    $display("checks=%0d fails=%0d", n_checks, n_fail);
    if (n_fail == 0 && n_checks > 0) $display("DONE - PASS");
    else $display("DONE - FAIL");
    $finish;
  endtask
  task run(input [3:0] o, input h);
    int n, lk, x, s, f, g;
    reg b, ir, rq;
    ir = $urandom_range(0, 1);
    f = (o > 4'hB) ? 0 : $urandom_range(0, 3);
    @(posedge clk_i);
    op <= o;
    hit <= h;
    ea <= $urandom_range(0, 20);
    srch <= $urandom_range(1, 20);
    irq <= ir;
    start_i <= 1'b1;
    @(posedge clk_i);
    start_i <= 1'b0;
    #1;
    n = 0;
    lk = 0;
    g = 0;
    // the bad-op pulse stands only in the cycle after the start edge
    b = (bad === 1'b1);
    rq = req;
    while (done !== 1'b1 && n < 300 && !(o > 4'hB && n == 3)) begin
      @(posedge clk_i);
      #1;
      n++;
      lk += (lock === 1'b1);
      b = b | (bad === 1'b1);
      // frozen edges hold the grant, so only live edges are modelled
      if (!(n >= 3 && n <= 2 + f) && grant !== (rq && lock !== 1'b1)) g++;
      rq = req;
      // freeze f edges mid-instruction, back to running well before done
      ce <= !(n >= 2 && n < 2 + f);
      // short request: must be held pending until the boundary
      if (n == 1) irq <= 1'b0;
    end
    check(g, 0);
    if (o > 4'hB) begin
      check(b, 1'b1);
      check(busy, 1'b0);
    end else begin
      // flush takes no address time, probe adds its tail
      x = (h ? tc[o] : tu[o]) + ((o == 7 || o == 8) ? 0 : ea) + (o == 11);
      s = (o == 9 || o == 10) ? srch : 0;
      check(n, x + s + f);
      check(tot, x + s);
      check({rd, pf, wr}, {mr[o][3:0], h ? 4'h0 : mp[o][3:0], mw[o][3:0]});
      check(lk, s);
      check(itake, ir);
      check(busy, 1'b0);
    end
  endtask
  initial begin
    void'($urandom(47));
    repeat (16) @(posedge clk_i);
    reset_i <= 1'b0;
    for (int o = 0; o < 16; o++) begin
      run(o[3:0], 1'b1);
      run(o[3:0], 1'b0);
    end
    close_out;
  end
  initial begin
    #100000;
    n_fail++;
    close_out;
  end
endmodule
bind mmu_instruction_timing_model mmu_timing_monitor i_mon (.clk_i(clk_i), .reset_i(reset_i), .ce_i(ce_i),
  .start_i(start_i), .op_i(op_i), .icache_hit_i(icache_hit_i), .ea_clocks_i(ea_clocks_i), .bus_req_i(bus_req_i),
  .busy_o(busy_o), .done_o(done_o), .bad_op_o(bad_op_o), .total_clocks_o(total_clocks_o), .reads_o(reads_o),
  .writes_o(writes_o), .irq_take_o(irq_take_o), .bus_grant_o(bus_grant_o), .locked_o(locked_o));

// file: dv/mmu_timing_monitor.sv
// assertions on the mmu timing model ports
`timescale 1ns/1ps
module mmu_timing_monitor (
  input wire clk_i,
  input wire reset_i,
  input wire ce_i,
  input wire start_i,
  input wire [3:0] op_i,
  input wire icache_hit_i,
  input wire [7:0] ea_clocks_i,
  input wire bus_req_i,
  input wire busy_o,
  input wire done_o,
  input wire bad_op_o,
  input wire [8:0] total_clocks_o,
  input wire [3:0] reads_o,
  input wire [3:0] writes_o,
  input wire irq_take_o,
  input wire bus_grant_o,
  input wire locked_o
);
  // one edge of slack: counts stand until the next start, except a preload total, which grows by the search length
  wire go = start_i && ce_i && !busy_o;
  default clocking @(posedge clk_i); endclocking
  default disable iff (reset_i);
  a_root_read: assert property (go && op_i == 4'h0 |-> ##2 writes_o == 4'h2 &&
    total_clocks_o == $past(ea_clocks_i, 2) + ($past(icache_hit_i, 2) ? 9'h004 : 9'h005))
    else $error("root read count wrong");
  a_win_read: assert property (go && op_i == 4'h3 |-> ##2
    total_clocks_o == $past(ea_clocks_i, 2) + 9'h008) else $error("window read count wrong");
  a_flush_count: assert property (go && op_i == 4'h7 |-> ##2
    total_clocks_o == ($past(icache_hit_i, 2) ? 9'h010 : 9'h012)) else $error("flush count wrong");
  a_probe_count: assert property (go && op_i == 4'hB |-> ##2 reads_o == 4'hC &&
    total_clocks_o == $past(ea_clocks_i, 2) + 9'h059) else $error("probe count wrong");
  a_bad_op: assert property (go && op_i > 4'hB |-> ##[1:2] bad_op_o) else $error("bad op missed");
  a_done_idle: assert property (done_o |-> !busy_o) else $error("busy at done");
  a_irq_boundary: assert property (irq_take_o |-> done_o) else $error("irq off boundary");
  a_lock_grant: assert property (locked_o |-> !bus_grant_o) else $error("grant in search");
  a_grant_req: assert property (bus_grant_o && $past(ce_i) |-> $past(bus_req_i)) else $error("grant unasked");
  a_ce_freeze: assert property (!$past(ce_i) |-> $stable(busy_o) && $stable(bus_grant_o) &&
    $stable(total_clocks_o) && $stable(locked_o)) else $error("state moved while frozen");
  c_preload: cover property (go && op_i == 4'h9);
  c_lock_req: cover property (locked_o && bus_req_i);
  c_irq: cover property (irq_take_o);
  c_freeze: cover property (!ce_i && busy_o);
endmodule
